// [rtl/gaac_in_filter.sv]
module gaac_in_filter
   import gaac_pkg::*;
#(
   parameter int STABLE_CYC = FILTER_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin_n,
   output logic asserted
);
   localparam int CW = $clog2(STABLE_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);

   logic sync1_q;
   logic sync2_q;
   logic level_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic level_d;
   logic differ;

   // Level changes only after STABLE_CYC cycles of a steady new value
   assign differ = sync2_q != level_q;
   assign level_d = (differ && cnt_q == LAST) ? sync2_q : level_q;
   assign cnt_d = (!differ || cnt_q == LAST) ? '0 : cnt_q + 1'b1;
   assign asserted = ~level_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         level_q <= 1'b1;
         cnt_q <= '0;
      end else begin
         sync1_q <= pin_n;
         sync2_q <= sync1_q;
         level_q <= level_d;
         cnt_q <= cnt_d;
      end
   end
endmodule // gaac_in_filter

// [rtl/gaac_pkg.sv]
package gaac_pkg;

   // ********************************************************************
   // Sizes and timing
   // ********************************************************************
   localparam int NUM_IN = 4;
   localparam int NUM_OUT = 3;
   localparam int NUM_EVT = 10;
   localparam int NUM_DLY = 5;
   localparam int CLK_HZ = 100_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int FILTER_MS = 50;
   localparam int ALARM_PULSE_MS = 1000;
   localparam int GM_PULSE_MS = 20;
   localparam int FILTER_CYC = FILTER_MS * CYC_PER_MS;
   localparam int ALARM_PULSE_CYC = ALARM_PULSE_MS * CYC_PER_MS;
   localparam int GM_PULSE_CYC = GM_PULSE_MS * CYC_PER_MS;

   // ********************************************************************
   // Register map (byte addresses, low address bits only)
   // ********************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_IN_CFG0 = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_OUT_MASK0 = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_ALARM_TIME = 8'h1C;
   localparam logic [ADDR_W-1:0] ADDR_DELAY0 = 8'h20;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h34;
   localparam logic [ADDR_W-1:0] ADDR_STRIDE = 8'h04;

   localparam int ACT_W = 3;
   localparam int ACT_LSB = 0;
   localparam int PRESET_W = 8;
   localparam int PRESET_LSB = 8;
   localparam int TIME_W = 24;
   localparam int DELAY_W = 16;
   localparam int ST_IN_LSB = 0;
   localparam int ST_OUT_LSB = 4;
   localparam int ST_EVT_LSB = 16;

   // Action codes
   localparam logic [ACT_W-1:0] ACT_NONE = 3'h0;
   localparam logic [ACT_W-1:0] ACT_RESET_PT = 3'h1;
   localparam logic [ACT_W-1:0] ACT_REACQUIRE = 3'h2;
   localparam logic [ACT_W-1:0] ACT_JAM_SYNC = 3'h3;
   localparam logic [ACT_W-1:0] ACT_NTP_UPDATE = 3'h4;
   localparam logic [ACT_W-1:0] ACT_RECALL = 3'h5;

   // Preset selection: two built-in, the rest user presets
   localparam logic [PRESET_W-1:0] PRESET_POWER_ON = 8'h00;
   localparam logic [PRESET_W-1:0] PRESET_FACTORY = 8'h01;

   // Event bit positions within an output mask
   localparam int EV_HW_FAULT = 0;
   localparam int EV_SUPPLY_FAULT = 1;
   localparam int EV_LOCK_ERR = 2;
   localparam int EV_LOCK_WARN = 3;
   localparam int EV_TIME_ERR = 4;
   localparam int EV_TIME_WARN = 5;
   localparam int EV_SECONDARY = 6;
   localparam int EV_ALARM_TIME = 7;
   localparam int EV_GM1_LOSS = 8;
   localparam int EV_GM2_LOSS = 9;
   localparam int DLY_EVT [NUM_DLY] = '{EV_HW_FAULT, EV_LOCK_ERR, EV_LOCK_WARN, EV_TIME_ERR, EV_TIME_WARN};

   // ********************************************************************
   // Carriers
   // ********************************************************************
   typedef struct packed {
      logic hw_fault;
      logic supply_one_lamp_red;
      logic supply_two_lamp_red;
      logic ref_red;
      logic ref_yellow;
      logic time_red;
      logic time_yellow;
      logic secondary_active;
      logic [1:0] ptp_leader;
   } gaac_cond_t;

   typedef struct packed {
      logic prog_time_reset;
      logic gnss_reset;
      logic jam_sync;
      logic ntp_update;
      logic preset_recall;
      logic [PRESET_W-1:0] preset_sel;
   } gaac_act_t;

endpackage

// [rtl/gaac_top.sv]
module gaac_top
   import gaac_pkg::*;
#(
   parameter int FILTER_CYCLES = FILTER_CYC,
   parameter int MS_CYCLES = CYC_PER_MS,
   parameter int ALARM_PULSE_CYCLES = ALARM_PULSE_CYC,
   parameter int GM_PULSE_CYCLES = GM_PULSE_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NUM_IN-1:0] general_pins_in_n,
   output logic [NUM_OUT-1:0] general_pins_out_n,
   output logic [NUM_OUT-1:0] general_pins_oe,
   input wire gaac_cond_t cond,
   input wire logic [TIME_W-1:0] prog_time,
   input wire logic tod_internal,
   output gaac_act_t act
);

   // ********************************************************************
   // Widths
   // ********************************************************************
   localparam int MSW = $clog2(MS_CYCLES + 1);
   localparam int APW = $clog2(ALARM_PULSE_CYCLES + 1);
   localparam int GPW = $clog2(GM_PULSE_CYCLES + 1);
   localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);
   localparam logic [APW-1:0] AP_LOAD = APW'(ALARM_PULSE_CYCLES);
   localparam logic [GPW-1:0] GP_LOAD = GPW'(GM_PULSE_CYCLES);

   // ********************************************************************
   // Bus slave
   // ********************************************************************
   logic bus_take;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_word;
   logic wr_pend_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;

   // Zero wait state: every transfer is taken in its address phase
   assign bus_take = hsel && hready && htrans[1];
   assign rd_addr = haddr[ADDR_W-1:0];
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         hrdata_q <= '0;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         wr_pend_q <= bus_take && hwrite;
         if (bus_take) begin
            wr_addr_q <= rd_addr;
         end
         if (bus_take && !hwrite) begin
            hrdata_q <= rd_word;
         end
      end
   end

   // ********************************************************************
   // Configuration registers
   // ********************************************************************
   logic [ACT_W-1:0] action_q [NUM_IN];
   logic [PRESET_W-1:0] preset_q [NUM_IN];
   logic [NUM_EVT-1:0] mask_q [NUM_OUT];
   logic [DELAY_W-1:0] delay_q [NUM_DLY];
   logic [TIME_W-1:0] alarm_time_q;
   logic [NUM_IN-1:0] in_hit_wr;
   logic [NUM_OUT-1:0] out_hit_wr;
   logic [NUM_DLY-1:0] dly_hit_wr;
   logic alarm_hit_wr;

   assign alarm_hit_wr = wr_pend_q && wr_addr_q == ADDR_ALARM_TIME;

   for (genvar i = 0; i < NUM_IN; i++) begin : g_in_cfg
      assign in_hit_wr[i] = wr_pend_q && wr_addr_q == ADDR_IN_CFG0 + ADDR_W'(i) * ADDR_STRIDE;
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            action_q[i] <= ACT_NONE;
            preset_q[i] <= PRESET_POWER_ON;
         end else if (in_hit_wr[i]) begin
            action_q[i] <= hwdata[ACT_LSB +: ACT_W];
            preset_q[i] <= hwdata[PRESET_LSB +: PRESET_W];
         end
      end
   end

   for (genvar j = 0; j < NUM_OUT; j++) begin : g_out_cfg
      assign out_hit_wr[j] = wr_pend_q && wr_addr_q == ADDR_OUT_MASK0 + ADDR_W'(j) * ADDR_STRIDE;
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            mask_q[j] <= '0;
         end else if (out_hit_wr[j]) begin
            mask_q[j] <= hwdata[NUM_EVT-1:0];
         end
      end
   end

   for (genvar k = 0; k < NUM_DLY; k++) begin : g_dly_cfg
      assign dly_hit_wr[k] = wr_pend_q && wr_addr_q == ADDR_DELAY0 + ADDR_W'(k) * ADDR_STRIDE;
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            delay_q[k] <= '0;
         end else if (dly_hit_wr[k]) begin
            delay_q[k] <= hwdata[DELAY_W-1:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alarm_time_q <= '0;
      end else if (alarm_hit_wr) begin
         alarm_time_q <= hwdata[TIME_W-1:0];
      end
   end

   // ********************************************************************
   // Command inputs
   // ********************************************************************
   logic [NUM_IN-1:0] in_level;
   logic [NUM_IN-1:0] in_prev_q;
   logic [NUM_IN-1:0] in_edge;
   logic [NUM_IN-1:0] hit_reset_pt;
   logic [NUM_IN-1:0] hit_reacquire;
   logic [NUM_IN-1:0] hit_jam;
   logic [NUM_IN-1:0] hit_ntp;
   logic [NUM_IN-1:0] hit_recall;
   logic [PRESET_W-1:0] recall_sel;
   gaac_act_t act_q;

   for (genvar i = 0; i < NUM_IN; i++) begin : g_in
      gaac_in_filter #(
         .STABLE_CYC(FILTER_CYCLES)
      ) u_filter (
         .hclk(hclk),
         .hresetn(hresetn),
         .pin_n(general_pins_in_n[i]),
         .asserted(in_level[i])
      );
      // ACT_NONE matches no decode below, so such an input does nothing
      assign hit_reset_pt[i] = in_edge[i] && action_q[i] == ACT_RESET_PT;
      assign hit_reacquire[i] = in_edge[i] && action_q[i] == ACT_REACQUIRE;
      assign hit_jam[i] = in_edge[i] && action_q[i] == ACT_JAM_SYNC;
      assign hit_ntp[i] = in_edge[i] && action_q[i] == ACT_NTP_UPDATE && tod_internal;
      assign hit_recall[i] = in_edge[i] && action_q[i] == ACT_RECALL;
   end

   assign in_edge = in_level & ~in_prev_q;

   // Lowest-numbered input wins when several recall in one cycle
   always_comb begin
      recall_sel = PRESET_POWER_ON;
      for (int i = NUM_IN - 1; i >= 0; i--) begin
         if (hit_recall[i]) begin
            recall_sel = preset_q[i];
         end
      end
   end

   assign act = act_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_prev_q <= '0;
         act_q <= '0;
      end else begin
         in_prev_q <= in_level;
         act_q.prog_time_reset <= |hit_reset_pt;
         act_q.gnss_reset <= |hit_reacquire;
         act_q.jam_sync <= |hit_jam;
         act_q.ntp_update <= |hit_ntp;
         act_q.preset_recall <= |hit_recall;
         if (|hit_recall) begin
            act_q.preset_sel <= recall_sel;
         end
      end
   end

   // ********************************************************************
   // Event sources
   // ********************************************************************
   logic [MSW-1:0] ms_cnt_q;
   logic ms_tick;
   logic time_match;
   logic match_prev_q;
   logic [APW-1:0] alarm_cnt_q;
   logic [1:0] leader_prev_q;
   logic [1:0] gm_fall;
   logic [GPW-1:0] gm_cnt_q [2];
   logic [NUM_EVT-1:0] evt_raw;
   logic [NUM_EVT-1:0] evt_vec;

   assign ms_tick = ms_cnt_q == MS_LAST;
   assign time_match = prog_time == alarm_time_q;
   assign gm_fall = leader_prev_q & ~cond.ptp_leader;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ms_cnt_q <= '0;
         match_prev_q <= 1'b0;
         alarm_cnt_q <= '0;
         leader_prev_q <= '0;
      end else begin
         ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
         match_prev_q <= time_match;
         leader_prev_q <= cond.ptp_leader;
         if (time_match && !match_prev_q) begin
            alarm_cnt_q <= AP_LOAD;
         end else if (alarm_cnt_q != '0) begin
            alarm_cnt_q <= alarm_cnt_q - 1'b1;
         end
      end
   end

   for (genvar p = 0; p < 2; p++) begin : g_gm
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            gm_cnt_q[p] <= '0;
         end else if (gm_fall[p]) begin
            gm_cnt_q[p] <= GP_LOAD;
         end else if (gm_cnt_q[p] != '0) begin
            gm_cnt_q[p] <= gm_cnt_q[p] - 1'b1;
         end
      end
   end

   assign evt_raw[EV_HW_FAULT] = cond.hw_fault;
   assign evt_raw[EV_SUPPLY_FAULT] = cond.supply_one_lamp_red || cond.supply_two_lamp_red;
   assign evt_raw[EV_LOCK_ERR] = cond.ref_red;
   assign evt_raw[EV_LOCK_WARN] = cond.ref_yellow;
   assign evt_raw[EV_TIME_ERR] = cond.time_red;
   assign evt_raw[EV_TIME_WARN] = cond.time_yellow;
   assign evt_raw[EV_SECONDARY] = cond.secondary_active;
   assign evt_raw[EV_ALARM_TIME] = alarm_cnt_q != '0;
   assign evt_raw[EV_GM1_LOSS] = gm_cnt_q[0] != '0;
   assign evt_raw[EV_GM2_LOSS] = gm_cnt_q[1] != '0;

   // ********************************************************************
   // Alarm qualification delays
   // ********************************************************************
   logic [DELAY_W:0] dly_cnt_q [NUM_DLY];
   logic [NUM_DLY-1:0] dly_ok;

   // Ticks run free, so the first one may come early: one tick past the delay ensures it fully elapsed
   for (genvar k = 0; k < NUM_DLY; k++) begin : g_dly
      assign dly_ok[k] = evt_raw[DLY_EVT[k]] && (delay_q[k] == '0 || dly_cnt_q[k] > {1'b0, delay_q[k]});
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            dly_cnt_q[k] <= '0;
         end else if (!evt_raw[DLY_EVT[k]]) begin
            dly_cnt_q[k] <= '0;
         end else if (ms_tick && dly_cnt_q[k] <= {1'b0, delay_q[k]}) begin
            dly_cnt_q[k] <= dly_cnt_q[k] + 1'b1;
         end
      end
   end

   always_comb begin
      evt_vec = evt_raw;
      for (int k = 0; k < NUM_DLY; k++) begin
         evt_vec[DLY_EVT[k]] = dly_ok[k];
      end
   end

   // ********************************************************************
   // Alarm outputs
   // ********************************************************************
   logic [NUM_OUT-1:0] out_assert;
   logic [NUM_OUT-1:0] out_n_q;
   logic [NUM_OUT-1:0] out_oe_q;
   logic [NUM_EVT-1:0] evt_q;

   for (genvar j = 0; j < NUM_OUT; j++) begin : g_out
      assign out_assert[j] = |(evt_vec & mask_q[j]);
   end

   assign general_pins_out_n = out_n_q;
   assign general_pins_oe = out_oe_q;

   // Open-drain: pull low while asserted, release otherwise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_n_q <= '1;
         out_oe_q <= '0;
         evt_q <= '0;
      end else begin
         out_n_q <= ~out_assert;
         out_oe_q <= out_assert;
         evt_q <= evt_vec;
      end
   end

   // ********************************************************************
   // Read selection
   // ********************************************************************
   always_comb begin
      rd_word = '0;
      for (int i = 0; i < NUM_IN; i++) begin
         if (rd_addr == ADDR_IN_CFG0 + ADDR_W'(i) * ADDR_STRIDE) begin
            rd_word[ACT_LSB +: ACT_W] = action_q[i];
            rd_word[PRESET_LSB +: PRESET_W] = preset_q[i];
         end
      end
      for (int j = 0; j < NUM_OUT; j++) begin
         if (rd_addr == ADDR_OUT_MASK0 + ADDR_W'(j) * ADDR_STRIDE) begin
            rd_word[NUM_EVT-1:0] = mask_q[j];
         end
      end
      for (int k = 0; k < NUM_DLY; k++) begin
         if (rd_addr == ADDR_DELAY0 + ADDR_W'(k) * ADDR_STRIDE) begin
            rd_word[DELAY_W-1:0] = delay_q[k];
         end
      end
      if (rd_addr == ADDR_ALARM_TIME) begin
         rd_word[TIME_W-1:0] = alarm_time_q;
      end
      if (rd_addr == ADDR_STATUS) begin
         rd_word[ST_IN_LSB +: NUM_IN] = in_level;
         rd_word[ST_OUT_LSB +: NUM_OUT] = out_oe_q;
         rd_word[ST_EVT_LSB +: NUM_EVT] = evt_q;
      end
   end

endmodule // gaac_top

// [verification/gaac_far_end.sv]
module gaac_far_end
   import gaac_pkg::*;
(
   input wire logic hclk,
   output logic [NUM_IN-1:0] pins_n,
   input wire logic [NUM_OUT-1:0] drive_oe,
   output logic [NUM_OUT-1:0] line_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Contacts and pulled-up alarm lines
   // ****************************************
   initial pins_n = '1;
   // Released open-drain line floats to the pull-up level
   assign line_n = ~drive_oe;

   task automatic press(input int idx, input int cyc);
      @(posedge hclk);
      pins_n[idx] <= 1'b0;
      repeat (cyc) @(posedge hclk);
      pins_n[idx] <= 1'b1;
   endtask
endmodule // gaac_far_end

// [verification/gaac_top_checker.sv]
module gaac_top_checker
   import gaac_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [NUM_IN-1:0] general_pins_in_n,
   input wire logic [NUM_OUT-1:0] general_pins_out_n,
   input wire logic [NUM_OUT-1:0] general_pins_oe,
   input wire logic tod_internal,
   input wire gaac_act_t act
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   wire logic [4:0] pulses = {act.prog_time_reset, act.gnss_reset, act.jam_sync, act.ntp_update, act.preset_recall};

   property p_bus_okay; hreadyout && !hresp; endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus stalled or answered with error");
   property p_oe_inverse; general_pins_oe == ~general_pins_out_n; endproperty
   a_oe_inverse: assert property (p_oe_inverse) else $error("pin enable not inverse of level");
   property p_reset_idle; $rose(hresetn) |-> general_pins_out_n == 3'h7 && pulses == 5'h0 && hrdata == 32'h0; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
   // Filter plus sync delay is far longer than eight cycles, so the pin was low then
   property p_act_cause; (|pulses) |-> $past(general_pins_in_n, 8) != 4'hF; endproperty
   a_act_cause: assert property (p_act_cause) else $error("action without a low pin");
   property p_ntp_gate; act.ntp_update |-> $past(tod_internal); endproperty
   a_ntp_gate: assert property (p_ntp_gate) else $error("time update with external source");
   property p_one_pulse; (|pulses) |=> pulses == 5'h0; endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("action pulse longer than one cycle");
   property p_sel_hold; !act.preset_recall |-> $stable(act.preset_sel); endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("preset selection moved without recall");
   property p_quiet; (general_pins_in_n == 4'hF) [*8] |-> pulses == 5'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("action while all pins released");
endmodule // gaac_top_checker

bind gaac_top gaac_top_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .general_pins_in_n(general_pins_in_n), .general_pins_out_n(general_pins_out_n),
   .general_pins_oe(general_pins_oe), .tod_internal(tod_internal), .act(act));

// [verification/test_gpi_action_alarm_control.sv]
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin errors++; $display("wrong value at %0t: %s", $time, msg); end end
module test_gpi_action_alarm_control
   import gaac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tod_internal = 1'b1, clr = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp;
   logic [3:0] pins_n;
   logic [2:0] out_n, oe, line_n;
   gaac_cond_t cond = '0;
   logic [23:0] prog_time = 24'h0;
   gaac_act_t act;
   logic [4:0] seen;
   int n, k, hits, errors = 0, checks = 0;
   wire logic [4:0] pulse_vec = {act.prog_time_reset, act.gnss_reset, act.jam_sync, act.ntp_update, act.preset_recall};

   always #5 hclk = ~hclk;

   gaac_top #(.FILTER_CYCLES(20), .MS_CYCLES(4), .ALARM_PULSE_CYCLES(50), .GM_PULSE_CYCLES(10)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .general_pins_in_n(pins_n), .general_pins_out_n(out_n), .general_pins_oe(oe), .cond(cond),
      .prog_time(prog_time), .tod_internal(tod_internal), .act(act));
   gaac_far_end u_far (.hclk(hclk), .pins_n(pins_n), .drive_oe(oe), .line_n(line_n));

   always @(posedge hclk) begin
      seen <= clr ? 5'h0 : seen | pulse_vec;
      hits <= clr ? 0 : hits + int'(|pulse_vec);
   end

   task automatic tally_and_finish;
      if (errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int t;
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
      t = 0;
      do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 20);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= wd;
      do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 40);
      rd = hrdata;
      if (t >= 40) begin errors++; tally_and_finish(); end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      `CHK(rd, exp, "register read")
   endtask

   task automatic act_run(input int pin, input int cyc, input logic [4:0] exp);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      u_far.press(pin, cyc);
      repeat (40) @(posedge hclk);
      `CHK(seen, exp, "action pulse set")
      `CHK(hits, int'(exp != 5'h0), "one action per press")
   endtask

   // Cycles until the line goes low, left in k
   task automatic wait_low(input int i);
      k = 0;
      while (line_n[i] !== 1'b0 && k < 30) begin @(posedge hclk); k++; end
      if (k >= 30) begin errors++; tally_and_finish(); end
   endtask

   // Time until line goes low, then how long it stays low
   task automatic pulse_len(input int i, output int lo);
      wait_low(i);
      lo = 0;
      while (line_n[i] === 1'b0 && lo < 200) begin @(posedge hclk); lo++; end
      if (lo >= 200) begin errors++; tally_and_finish(); end
   endtask

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      // ********************************************
      // Register reset values, unmapped place
      // ********************************************
      rd_chk(ADDR_IN_CFG0, 32'h0);
      rd_chk(ADDR_OUT_MASK0, 32'h0);
      bus(1'b1, 8'h40, 32'hFFFFFFFF);
      rd_chk(8'h40, 32'h0);
      // ********************************************
      // Every action code, each input in turn
      // ********************************************
      for (int c = 1; c <= 5; c++) begin
         bus(1'b1, ADDR_IN_CFG0 + 8'((c - 1) % 4) * ADDR_STRIDE, {16'h0, 8'h07, 5'h0, 3'(c)});
         act_run((c - 1) % 4, 40, 5'h10 >> (c - 1));
      end
      `CHK(act.preset_sel, 8'h07, "recalled preset")
      rd_chk(ADDR_IN_CFG0 + ADDR_STRIDE, {16'h0, 8'h07, 5'h0, ACT_REACQUIRE});
      tod_internal <= 1'b0;
      act_run(3, 40, 5'h0);
      tod_internal <= 1'b1;
      act_run(1, 10, 5'h0);
      bus(1'b1, ADDR_IN_CFG0, {29'h0, ACT_NONE});
      act_run(0, 40, 5'h0);
      act_run(2, 150, 5'h04);
      `CHK(u_dut.u_chk.pulses, 5'h0, "no pulse long after release")
      // ********************************************
      // Level events on one output, ORed
      // ********************************************
      cond.ptp_leader <= 2'h3;
      bus(1'b1, ADDR_OUT_MASK0, 32'h1 << EV_HW_FAULT | 32'h1 << EV_SUPPLY_FAULT | 32'h1 << EV_SECONDARY);
      for (int e = 0; e < 4; e++) begin
         cond <= cond | (10'h200 >> (e == 3 ? 7 : e));
         repeat (3) @(posedge hclk);
         `CHK(line_n[0], 1'b0, "level event asserts")
         cond <= 10'h003;
         repeat (3) @(posedge hclk);
         `CHK(line_n[0], 1'b1, "level event clears")
      end
      // ********************************************
      // Qualification delay with restart
      // ********************************************
      bus(1'b1, ADDR_DELAY0 + ADDR_STRIDE, 32'h3);
      bus(1'b1, ADDR_OUT_MASK0 + ADDR_STRIDE, 32'h1 << EV_LOCK_ERR);
      // Bursts of 11 cycles stay under the 12 cycles of a 3 ms delay
      for (int r = 0; r < 26; r++) begin
         cond.ref_red <= (r % 13) < 11;
         @(posedge hclk);
         `CHK(line_n[1], 1'b1, "short condition held back")
      end
      cond.ref_red <= 1'b1;
      wait_low(1);
      `CHK(k >= 12 && k <= 20, 1'b1, "delay length")
      cond.ref_red <= 1'b0;
      // ********************************************
      // Grandmaster loss pulses, per port
      // ********************************************
      bus(1'b1, ADDR_OUT_MASK0 + ADDR_STRIDE, 32'h1 << EV_GM1_LOSS);
      bus(1'b1, ADDR_OUT_MASK0 + 2 * ADDR_STRIDE, 32'h1 << EV_GM2_LOSS);
      cond.ptp_leader <= 2'h2;
      pulse_len(1, n);
      `CHK(n, 10, "port one loss pulse")
      `CHK(line_n[2], 1'b1, "other port quiet")
      cond.ptp_leader <= 2'h0;
      pulse_len(2, n);
      `CHK(n, 10, "port two loss pulse")
      // ********************************************
      // Alarm time one-shot
      // ********************************************
      bus(1'b1, ADDR_ALARM_TIME, 32'h00123456);
      bus(1'b1, ADDR_OUT_MASK0, 32'h1 << EV_ALARM_TIME);
      prog_time <= 24'h123456;
      @(posedge hclk);
      prog_time <= 24'h123457;
      pulse_len(0, n);
      `CHK(n, 50, "alarm time pulse")
      tally_and_finish();
   end
endmodule // test_gpi_action_alarm_control
